// >>> src/nbl_defines.svh
// constants for the nand block-lock and otp host controller
`ifndef NBL_DEFINES_SVH
`define NBL_DEFINES_SVH
// ==========================================================================
// nand command codes
`define NBL_CMD_LOCK 8'h2a
`define NBL_CMD_TIGHT 8'h2c
`define NBL_CMD_LOCK_STATUS 8'h7a
`define NBL_CMD_SET_FEATURE 8'hef
`define NBL_CMD_READ1 8'h00
`define NBL_CMD_READ2 8'h30
`define NBL_CMD_PROG1 8'h80
`define NBL_CMD_PROG2 8'h10
`define NBL_CMD_STATUS 8'h70
`define NBL_FEAT_OTP_ADDR 8'h90
// ==========================================================================
// apb register offsets
`define NBL_REG_CTRL 12'h000
`define NBL_REG_ARG 12'h004
`define NBL_REG_STAT 12'h008
`define NBL_REG_RESULT 12'h00c
`define NBL_REG_PINS 12'h010
// ==========================================================================
// op codes written to ctrl[3:0]; ctrl bit 8 starts
`define NBL_OP_LOCK 4'h1
`define NBL_OP_TIGHT 4'h2
`define NBL_OP_LOCK_STATUS 4'h3
`define NBL_OP_FEATURE 4'h4
`define NBL_OP_READ_BYTE 4'h5
`define NBL_OP_PROG_BYTE 4'h6
`define NBL_OP_STATUS 4'h7
`define NBL_CTRL_GO_BIT 8
// ==========================================================================
// otp page range and mode values
`define NBL_OTP_PAGE_MIN 8'h02
`define NBL_OTP_PAGE_MAX 8'h1f
`define NBL_MODE_NORMAL 8'h00
`define NBL_MODE_OTP 8'h01
`define NBL_MODE_PROTECT 8'h03
`define NBL_REPEAT_PROTECT_STATUS 8'h60
// ==========================================================================
// bus timing: strobe phase lasts this count plus one cycle (100 ns at 20 MHz)
`define NBL_STROBE_CYCLES 4'h1
`endif

// >>> src/nbl_pkg.sv
// types for the nand block-lock and otp host controller
package nbl_pkg;
    // ======================================================================
    // sequencer states, gray along the main path
    typedef enum logic [3:0] {
        NBL_IDLE = 4'b0000,
        NBL_CMD = 4'b0001,
        NBL_ADDR = 4'b0011,
        NBL_DATA = 4'b0010,
        NBL_CMD2 = 4'b0110,
        NBL_WAIT = 4'b0111,
        NBL_READ = 4'b0101,
        NBL_DONE = 4'b0100
    } nbl_state_t;
endpackage

// >>> src/nbl_host.sv
// host controller issuing block-lock and otp sequences to an async nand
`timescale 1ns/100ps
`include "nbl_defines.svh"
module nbl_host #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic nand_cle,
    output logic nand_ale,
    output logic nand_we_n,
    output logic read_enable_n,
    output logic nand_ce_n,
    output logic write_protect_n,
    output logic [7:0] nand_dq_out,
    output logic nand_dq_oe,
    input wire logic [7:0] nand_dq_in,
    input wire logic ready_busy_n
);
    // ======================================================================
    // state record
    typedef struct packed {
        nbl_pkg::nbl_state_t st;
        logic [3:0] op;
        logic [23:0] arg;      // [7:0] page/value, [20:8] column/block
        logic [7:0] data;
        logic [7:0] result;
        logic [2:0] idx;       // address or parameter cycle counter
        logic [3:0] tmr;
        logic ph;              // strobe phase: 0 low, 1 high
        logic busy;
        logic err;
        logic wp;
        logic [1:0] rb_sync;
        logic [7:0] mode;
        logic [7:0] last_otp_page;
        logic cle, ale, we_n, re_n, oe;
        logic [7:0] dq;
        logic [31:0] rdata;
        logic rdy;
    } nbl_s_t;
    nbl_s_t s_reg, s_next;
    logic cmd_go;
    logic rb_ready;
    assign rb_ready = s_reg.rb_sync[1];
    assign cmd_go = s_reg.rdy == 1'b1 && psel && penable && pwrite && !s_reg.busy
        && paddr == `NBL_REG_CTRL && pwdata[`NBL_CTRL_GO_BIT];

    // address cycle count per op
    function automatic logic [2:0] addr_cycles(input logic [3:0] op);
        case (op)
            `NBL_OP_LOCK_STATUS: addr_cycles = 3'd3;
            `NBL_OP_FEATURE: addr_cycles = 3'd1;
            `NBL_OP_READ_BYTE, `NBL_OP_PROG_BYTE: addr_cycles = 3'd5;
            default: addr_cycles = 3'd0;
        endcase
    endfunction

    // ======================================================================
    // next-state logic: apb slave plus nand strobe sequencer
    always_comb begin
        s_next = s_reg;
        s_next.rb_sync = {s_reg.rb_sync[0], ready_busy_n};
        s_next.rdy = 1'b0;
        // apb: single wait state so every access answers one cycle into access
        // a write lands only at the edge where the master sees pready high
        if (psel && penable) begin
            s_next.rdy = !s_reg.rdy;
            if (pwrite && s_reg.rdy) begin
                unique case (paddr)
                    `NBL_REG_ARG: s_next.arg = pwdata[23:0];
                    `NBL_REG_PINS: begin
                        s_next.wp = pwdata[0];
                    end
                    default: ;
                endcase
            end else if (!pwrite && !s_reg.rdy) begin
                unique case (paddr)
                    `NBL_REG_CTRL: s_next.rdata = {28'h000_0000, s_reg.op};
                    `NBL_REG_ARG: s_next.rdata = {8'h00, s_reg.arg};
                    `NBL_REG_STAT: s_next.rdata = {16'h0000, s_reg.mode, 5'h00, s_reg.err,
                        rb_ready, s_reg.busy};
                    `NBL_REG_RESULT: s_next.rdata = {24'h00_0000, s_reg.result};
                    `NBL_REG_PINS: s_next.rdata = {31'h0000_0000, s_reg.wp};
                    default: s_next.rdata = 32'h0000_0000;
                endcase
            end
        end
        if (cmd_go) begin
            s_next.op = pwdata[3:0];
            s_next.err = 1'b0;
            s_next.busy = 1'b1;
            s_next.st = nbl_pkg::NBL_CMD;
            s_next.idx = 3'd0;
            s_next.ph = 1'b0;
            s_next.tmr = 4'h0;
            // tight refused unless write protect released
            if (pwdata[3:0] == `NBL_OP_TIGHT && !s_reg.wp) begin
                s_next.err = 1'b1;
                s_next.busy = 1'b0;
                s_next.st = nbl_pkg::NBL_IDLE;
            end
            // otp programs must go in ascending page order
            if (pwdata[3:0] == `NBL_OP_PROG_BYTE && s_reg.mode == `NBL_MODE_OTP
                && (s_reg.arg[7:0] < s_reg.last_otp_page || s_reg.arg[7:0] < `NBL_OTP_PAGE_MIN
                || s_reg.arg[7:0] > `NBL_OTP_PAGE_MAX)) begin
                s_next.err = 1'b1;
                s_next.busy = 1'b0;
                s_next.st = nbl_pkg::NBL_IDLE;
            end
        end
        // strobe pacing: each phase lasts NBL_STROBE_CYCLES plus one cycles
        if (s_reg.st != nbl_pkg::NBL_IDLE && s_reg.st != nbl_pkg::NBL_WAIT) begin
            if (s_reg.tmr != `NBL_STROBE_CYCLES) begin
                s_next.tmr = s_reg.tmr + 4'h1;
            end else begin
                s_next.tmr = 4'h0;
                s_next.ph = !s_reg.ph;
            end
        end
        if (s_reg.tmr == `NBL_STROBE_CYCLES) begin
            unique case (s_reg.st)
                nbl_pkg::NBL_IDLE, nbl_pkg::NBL_WAIT: ;
                nbl_pkg::NBL_CMD, nbl_pkg::NBL_ADDR, nbl_pkg::NBL_DATA, nbl_pkg::NBL_CMD2: begin
                    if (!s_reg.ph) begin
                        s_next.we_n = 1'b1;  // rising edge latches the cycle
                    end else begin
                        s_next.cle = 1'b0;
                        s_next.ale = 1'b0;
                        s_next.oe = 1'b0;
                        if (s_reg.st == nbl_pkg::NBL_CMD) begin
                            if (addr_cycles(s_reg.op) != 3'd0) s_next.st = nbl_pkg::NBL_ADDR;
                            else if (s_reg.op == `NBL_OP_STATUS) s_next.st = nbl_pkg::NBL_READ;
                            else s_next.st = nbl_pkg::NBL_DONE;
                        end else if (s_reg.st == nbl_pkg::NBL_ADDR) begin
                            s_next.idx = s_reg.idx + 3'd1;
                            if (s_reg.idx + 3'd1 == addr_cycles(s_reg.op)) begin
                                s_next.idx = 3'd0;
                                if (s_reg.op == `NBL_OP_FEATURE || s_reg.op == `NBL_OP_PROG_BYTE)
                                    s_next.st = nbl_pkg::NBL_DATA;
                                else if (s_reg.op == `NBL_OP_READ_BYTE) s_next.st = nbl_pkg::NBL_CMD2;
                                else s_next.st = nbl_pkg::NBL_READ;  // lock status byte read
                            end
                        end else if (s_reg.st == nbl_pkg::NBL_DATA) begin
                            s_next.idx = s_reg.idx + 3'd1;
                            // four parameter bytes for the feature write
                            if (s_reg.op == `NBL_OP_PROG_BYTE || s_reg.idx == 3'd3) begin
                                s_next.st = (s_reg.op == `NBL_OP_PROG_BYTE) ? nbl_pkg::NBL_CMD2
                                    : nbl_pkg::NBL_WAIT;
                                // mode tracks the value just written
                                if (s_reg.op == `NBL_OP_FEATURE) s_next.mode = s_reg.arg[7:0];
                            end
                        end else begin
                            s_next.st = nbl_pkg::NBL_WAIT;
                            if (s_reg.op == `NBL_OP_PROG_BYTE && s_reg.mode == `NBL_MODE_OTP)
                                s_next.last_otp_page = s_reg.arg[7:0];
                        end
                    end
                end
                nbl_pkg::NBL_READ: begin
                    if (!s_reg.ph) begin
                        s_next.re_n = 1'b1;
                        s_next.result = nand_dq_in;  // sampled on the rising read strobe
                        s_next.st = nbl_pkg::NBL_DONE;
                    end
                end
                nbl_pkg::NBL_DONE: ;
                default: s_next.st = nbl_pkg::NBL_IDLE;
            endcase
        end
        // drive strobes at the start of each low phase
        if (s_reg.tmr == 4'h0 && !s_reg.ph) begin
            unique case (s_reg.st)
                nbl_pkg::NBL_CMD: begin
                    s_next.cle = 1'b1;
                    s_next.we_n = 1'b0;
                    s_next.oe = 1'b1;
                    unique case (s_reg.op)
                        `NBL_OP_LOCK: s_next.dq = `NBL_CMD_LOCK;
                        `NBL_OP_TIGHT: s_next.dq = `NBL_CMD_TIGHT;
                        `NBL_OP_LOCK_STATUS: s_next.dq = `NBL_CMD_LOCK_STATUS;
                        `NBL_OP_FEATURE: s_next.dq = `NBL_CMD_SET_FEATURE;
                        `NBL_OP_READ_BYTE: s_next.dq = `NBL_CMD_READ1;
                        `NBL_OP_PROG_BYTE: s_next.dq = `NBL_CMD_PROG1;
                        default: s_next.dq = `NBL_CMD_STATUS;  // plain status only
                    endcase
                end
                nbl_pkg::NBL_ADDR: begin
                    s_next.ale = 1'b1;
                    s_next.we_n = 1'b0;
                    s_next.oe = 1'b1;
                    if (s_reg.op == `NBL_OP_FEATURE) s_next.dq = `NBL_FEAT_OTP_ADDR;
                    else if (s_reg.op == `NBL_OP_LOCK_STATUS) begin
                        // block address, invert bit forced low
                        unique case (s_reg.idx)
                            3'd0: s_next.dq = {s_reg.arg[9:8], 6'h00};
                            3'd1: s_next.dq = s_reg.arg[17:10];
                            default: s_next.dq = {6'h00, s_reg.arg[19:18]};
                        endcase
                    end else begin
                        // 13-bit column then page; zero column protects
                        unique case (s_reg.idx)
                            3'd0: s_next.dq = s_reg.arg[15:8];
                            3'd1: s_next.dq = {3'h0, s_reg.arg[20:16]};
                            3'd2: s_next.dq = s_reg.arg[7:0];
                            default: s_next.dq = 8'h00;
                        endcase
                    end
                end
                nbl_pkg::NBL_DATA: begin
                    s_next.we_n = 1'b0;
                    s_next.oe = 1'b1;
                    if (s_reg.op == `NBL_OP_PROG_BYTE) s_next.dq = s_reg.arg[23] ? 8'h00 : 8'hff;
                    else s_next.dq = (s_reg.idx == 3'd0) ? s_reg.arg[7:0] : 8'h00;
                end
                nbl_pkg::NBL_CMD2: begin
                    s_next.cle = 1'b1;
                    s_next.we_n = 1'b0;
                    s_next.oe = 1'b1;
                    s_next.dq = (s_reg.op == `NBL_OP_READ_BYTE) ? `NBL_CMD_READ2 : `NBL_CMD_PROG2;
                end
                nbl_pkg::NBL_READ: s_next.re_n = 1'b0;  // byte valid from falling edge
                default: ;
            endcase
        end
        // wait for the device's busy period to end
        if (s_reg.st == nbl_pkg::NBL_WAIT && rb_ready && s_reg.tmr == `NBL_STROBE_CYCLES) begin
            s_next.st = (s_reg.op == `NBL_OP_READ_BYTE) ? nbl_pkg::NBL_READ : nbl_pkg::NBL_DONE;
            s_next.ph = 1'b0;
            s_next.tmr = 4'h0;
        end else if (s_reg.st == nbl_pkg::NBL_WAIT) begin
            s_next.tmr = (s_reg.tmr == `NBL_STROBE_CYCLES) ? s_reg.tmr : s_reg.tmr + 4'h1;
        end
        if (s_reg.st == nbl_pkg::NBL_DONE) begin
            s_next.busy = 1'b0;
            s_next.st = nbl_pkg::NBL_IDLE;
        end
    end

    // state register; reset leaves write protect asserted and bus idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '{st: nbl_pkg::NBL_IDLE, op: 4'h0, arg: 24'h00_0000, data: 8'h00,
                result: 8'h00, idx: 3'd0, tmr: 4'h0, ph: 1'b0, busy: 1'b0, err: 1'b0,
                wp: 1'b0, rb_sync: 2'b00, mode: `NBL_MODE_NORMAL, last_otp_page: 8'h00,
                cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, oe: 1'b0, dq: 8'h00,
                rdata: 32'h0000_0000, rdy: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata = s_reg.rdata;
    assign pready = s_reg.rdy;
    assign pslverr = 1'b0;
    assign nand_cle = s_reg.cle;
    assign nand_ale = s_reg.ale;
    assign nand_we_n = s_reg.we_n;
    assign read_enable_n = s_reg.re_n;
    assign nand_ce_n = !s_reg.busy;
    assign write_protect_n = s_reg.wp;
    assign nand_dq_out = s_reg.dq;
    assign nand_dq_oe = s_reg.oe;
endmodule

// >>> tb/nbl_host_checker.sv
// concurrent checks on the ports of the nand block-lock host controller
`timescale 1ns/100ps
`include "nbl_defines.svh"
module nbl_host_checker #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic nand_cle,
    input wire logic nand_ale,
    input wire logic nand_we_n,
    input wire logic read_enable_n,
    input wire logic nand_ce_n,
    input wire logic write_protect_n,
    input wire logic [7:0] nand_dq_out,
    input wire logic nand_dq_oe,
    input wire logic [7:0] nand_dq_in,
    input wire logic ready_busy_n
);
    // ======================================================================
    // bus handshake and flash strobe relations
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_pready_pulse: assert property (pready |=> !pready) else $error("pready held longer than one cycle");
    chk_pready_wait: assert property (psel && penable && !pready |=> pready) else $error("apb answer late");
    chk_no_slverr: assert property (!pslverr) else $error("pslverr raised");
    chk_we_low: assert property ($fell(nand_we_n) |=> nand_we_n) else $error("write strobe low longer than one cycle");
    chk_we_high: assert property ($rose(nand_we_n) |=> nand_we_n) else $error("write strobe high phase short");
    chk_latch_stable: assert property ($fell(nand_we_n) |=> $stable(nand_cle) && $stable(nand_ale) && $stable(nand_dq_out))
        else $error("cycle type or data moved under the write strobe");
    chk_cle_ale_excl: assert property (!(nand_cle && nand_ale)) else $error("cle and ale both high");
    chk_strobe_sel: assert property (!nand_we_n || !read_enable_n |-> !nand_ce_n) else $error("strobe without chip select");
    chk_read_no_drive: assert property (!read_enable_n |-> !nand_dq_oe) else $error("host drives dq while reading");
    chk_tight_wp_high: assert property ($fell(nand_we_n) && nand_cle && nand_dq_out == `NBL_CMD_TIGHT |-> write_protect_n)
        else $error("lock-tight sent with write protect low");
    chk_no_enh_status: assert property (!nand_we_n && nand_cle |-> nand_dq_out != 8'h78)
        else $error("enhanced status command sent");
    cover property ($fell(nand_we_n) && nand_cle && nand_dq_out == `NBL_CMD_LOCK);
    cover property ($fell(nand_we_n) && nand_cle && nand_dq_out == `NBL_CMD_TIGHT);
    cover property ($fell(read_enable_n));
endmodule
bind nbl_host nbl_host_checker #(.ADDR_W(ADDR_W)) u_nbl_host_checker (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .nand_cle, .nand_ale, .nand_we_n, .read_enable_n, .nand_ce_n,
    .write_protect_n, .nand_dq_out, .nand_dq_oe, .nand_dq_in, .ready_busy_n);

// >>> tb/nbl_nand_model.sv
// behavioural nand target answering block-lock and otp command sequences
`timescale 1ns/100ps
`include "nbl_defines.svh"
module nbl_nand_model #(
    parameter bit LOCK_PIN = 1'b1,
    parameter int BUSY_NS = 2000
) (
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic re_n,
    input wire logic ce_n,
    input wire logic wp_n,
    input wire logic [7:0] dq,
    output logic [7:0] dq_q,
    output logic rb_n
);
    // lock pin high starts fully locked
    logic locked = LOCK_PIN;
    logic tight = 1'b0, prot = 1'b0, fail = 1'b0, st7 = 1'b1;
    logic [7:0] cmd = 8'h00, mode = 8'h00, obyte = 8'h00, wbyte = 8'hff;
    logic [7:0] adr [0:4];
    logic [7:0] otp [0:31];
    int parts [0:31];
    int na = 0;
    int nd = 0;
    initial begin
        rb_n = 1'b1;
        foreach (otp[i]) begin
            otp[i] = 8'hff;
            parts[i] = 0;
        end
    end
    // released bus shows inverse of last byte, never a stale copy
    assign dq_q = re_n ? ~obyte : obyte;
    function automatic logic in_otp(input logic [7:0] p);
        return p >= `NBL_OTP_PAGE_MIN && p <= `NBL_OTP_PAGE_MAX;
    endfunction
    // busy held for the whole modelled count
    task automatic go_busy();
        rb_n = 1'b0;
        #(BUSY_NS);
        rb_n = 1'b1;
    endtask
    // ======================================================================
    // command, address and data latch on the write strobe rise
    always @(posedge we_n) begin
        if (!ce_n && cle) begin
            case (dq)
                // lock ignored when disabled or tight
                `NBL_CMD_LOCK: if (LOCK_PIN && !tight) locked = 1'b1;
                `NBL_CMD_TIGHT: if (LOCK_PIN) tight = 1'b1;
                // status bit 5 follows busy, bit 0 pass or fail
                `NBL_CMD_STATUS: obyte = {st7, rb_n, rb_n, 4'h0, fail};
                // otp-mode reads go to otp pages, protected or not
                `NBL_CMD_READ2: begin
                    if (mode == `NBL_MODE_OTP && in_otp(adr[2])) obyte = otp[adr[2][4:0]];
                    go_busy();
                end
                `NBL_CMD_PROG2: begin
                    st7 = wp_n;
                    fail = 1'b0;
                    // protect once, a repeat leaves status 60h
                    if (mode == `NBL_MODE_PROTECT) begin
                        if (prot) st7 = 1'b0;
                        else if (wbyte == 8'h00 && adr[0] == 8'h00 && adr[3] == 8'h00) prot = 1'b1;
                    end else if (mode == `NBL_MODE_OTP) begin
                        // refuse when protected, out of range or over eight partials
                        if (prot || !in_otp(adr[2]) || parts[adr[2][4:0]] == 8) fail = 1'b1;
                        else begin
                            otp[adr[2][4:0]] = otp[adr[2][4:0]] & wbyte;
                            parts[adr[2][4:0]]++;
                        end
                    // locked blocks refused, unlocked ones complete
                    end else if (locked) st7 = 1'b0;
                    go_busy();
                end
                default: begin
                    cmd = dq;
                    na = 0;
                    nd = 0;
                end
            endcase
        end else if (!ce_n && ale) begin
            if (na < 5) adr[na] = dq;
            na++;
            // per-block protection byte after three block cycles
            if (cmd == `NBL_CMD_LOCK_STATUS && na == 3) obyte = tight ? 8'h01 : (locked ? 8'h02 : 8'h06);
        end else if (!ce_n) begin
            if (nd == 0) wbyte = dq;
            // mode switch after the fourth parameter
            if (cmd == `NBL_CMD_SET_FEATURE && nd == 3 && adr[0] == `NBL_FEAT_OTP_ADDR) mode = wbyte;
            nd++;
        end
    end
    // write-protect low clears tight and relocks everything
    always @(negedge wp_n) begin
        if (LOCK_PIN) begin
            tight = 1'b0;
            locked = 1'b1;
        end
    end
endmodule

// >>> tb/tb.sv
// self-checking bench for the nand block-lock and otp host controller
`timescale 1ns/100ps
`include "nbl_defines.svh"
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, nand_cle, nand_ale, nand_we_n, read_enable_n, nand_ce_n, write_protect_n;
    logic nand_dq_oe, ready_busy_n;
    logic [7:0] nand_dq_out, nand_dq_in, pg;
    logic [12:0] col;
    logic [11:0] blk;
    int bad_count = 0;
    int n_tests = 0;
    nbl_host u_nbl_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .nand_cle(nand_cle),
        .nand_ale(nand_ale), .nand_we_n(nand_we_n), .read_enable_n(read_enable_n), .nand_ce_n(nand_ce_n),
        .write_protect_n(write_protect_n), .nand_dq_out(nand_dq_out), .nand_dq_oe(nand_dq_oe),
        .nand_dq_in(nand_dq_in), .ready_busy_n(ready_busy_n));
    nbl_nand_model u_nbl_nand_model (.cle(nand_cle), .ale(nand_ale), .we_n(nand_we_n), .re_n(read_enable_n),
        .ce_n(nand_ce_n), .wp_n(write_protect_n), .dq(nand_dq_out), .dq_q(nand_dq_in), .rb_n(ready_busy_n));
    // 20 MHz clock
    initial begin
        forever #25 pclk = ~pclk;
    end
    // ======================================================================
    // expectation helpers, compare and verdict
    function automatic logic [7:0] lock_code(input logic is_tight);
        return is_tight ? 8'h01 : 8'h02;
    endfunction
    function automatic logic [7:0] otp_next(input logic [7:0] old, input logic zero);
        return zero ? 8'h00 : old;
    endfunction
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // one apb transfer; entered just after a rising edge, waits for pready with a bound
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        // a wait that runs out counts as a mismatch
        if (pready !== 1'b1) bad_count++;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // start an op and poll busy; leaves the last status word in rd
    task automatic op(input logic [3:0] code, input logic [31:0] arg);
        int n;
        n = 0;
        apb(1'b1, `NBL_REG_ARG, arg);
        apb(1'b1, `NBL_REG_CTRL, 32'h0000_0100 | {28'h000_0000, code});
        do begin
            apb(1'b0, `NBL_REG_STAT, 32'h0000_0000);
            n++;
        end while (rd[0] !== 1'b0 && n < 500);
        if (rd[0] !== 1'b0) bad_count++;
    endtask
    task automatic result(input string name, input logic [7:0] exp);
        apb(1'b0, `NBL_REG_RESULT, 32'h0000_0000);
        check(name, rd[7:0], exp);
    endtask
    // ======================================================================
    // main sequence
    initial begin
        void'($urandom(32'h9cf3));
        pg = 8'($urandom_range(2, 30));
        col = 13'($urandom_range(0, 2111));
        blk = 12'($urandom());
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("wp_reset", 8'(write_protect_n), 8'h00);
        apb(1'b0, 12'h040, 32'h0000_0000);
        check("unmapped", rd[7:0], 8'h00);
        op(`NBL_OP_TIGHT, 32'h0000_0000);
        check("tight_refused", 8'(rd[2]), 8'h01);
        check("tight_state", 8'(u_nbl_nand_model.tight), 8'h00);
        apb(1'b1, `NBL_REG_PINS, 32'h0000_0001);
        op(`NBL_OP_LOCK_STATUS, {12'h000, blk, 8'h00});
        result("status_boot", lock_code(1'b0));
        check("invert_bit", 8'(u_nbl_nand_model.adr[0][0]), 8'h00);
        op(`NBL_OP_LOCK, 32'h0000_0000);
        op(`NBL_OP_PROG_BYTE, {8'h00, 1'b1, 2'b00, col, pg});
        op(`NBL_OP_STATUS, 32'h0000_0000);
        check("locked_prog", 8'(rd[2]), 8'h00);
        apb(1'b0, `NBL_REG_RESULT, 32'h0000_0000);
        check("locked_bit7", 8'(rd[7]), 8'h00);
        op(`NBL_OP_TIGHT, 32'h0000_0000);
        op(`NBL_OP_LOCK, 32'h0000_0000);
        op(`NBL_OP_LOCK_STATUS, {12'h000, blk, 8'h00});
        result("status_tight", lock_code(1'b1));
        apb(1'b1, `NBL_REG_PINS, 32'h0000_0000);
        apb(1'b1, `NBL_REG_PINS, 32'h0000_0001);
        op(`NBL_OP_LOCK_STATUS, {12'h000, blk, 8'h00});
        result("status_wp_toggle", lock_code(1'b0));
        op(`NBL_OP_FEATURE, {24'h00_0000, `NBL_MODE_OTP});
        check("mode_otp", u_nbl_nand_model.mode, `NBL_MODE_OTP);
        op(`NBL_OP_READ_BYTE, {8'h00, 1'b0, 2'b00, col, pg});
        result("otp_blank", 8'hff);
        op(`NBL_OP_PROG_BYTE, {8'h00, 1'b1, 2'b00, col, pg});
        op(`NBL_OP_READ_BYTE, {8'h00, 1'b0, 2'b00, col, pg});
        result("otp_written", otp_next(8'hff, 1'b1));
        op(`NBL_OP_STATUS, 32'h0000_0000);
        apb(1'b0, `NBL_REG_RESULT, 32'h0000_0000);
        check("otp_status", rd[7:0] & 8'h21, 8'h20); // ready, passed
        op(`NBL_OP_PROG_BYTE, {8'h00, 1'b1, 2'b00, col, pg - 8'h01});
        check("otp_descend", 8'(rd[2]), 8'h01);
        op(`NBL_OP_PROG_BYTE, {8'h00, 1'b1, 2'b00, col, 8'h20});
        check("otp_range", 8'(rd[2]), 8'h01);
        op(`NBL_OP_FEATURE, {24'h00_0000, `NBL_MODE_PROTECT});
        op(`NBL_OP_PROG_BYTE, {8'h00, 1'b1, 15'h0000, pg + 8'h01});
        check("protected", 8'(u_nbl_nand_model.prot), 8'h01);
        op(`NBL_OP_PROG_BYTE, {8'h00, 1'b1, 15'h0000, pg + 8'h01});
        op(`NBL_OP_STATUS, 32'h0000_0000);
        result("repeat_protect", `NBL_REPEAT_PROTECT_STATUS);
        op(`NBL_OP_FEATURE, {24'h00_0000, `NBL_MODE_OTP});
        op(`NBL_OP_READ_BYTE, {8'h00, 1'b0, 2'b00, col, pg});
        result("otp_read_protected", 8'h00);
        op(`NBL_OP_FEATURE, {24'h00_0000, `NBL_MODE_NORMAL});
        check("mode_normal", u_nbl_nand_model.mode, `NBL_MODE_NORMAL);
        conclude();
    end
    // watchdog: the sequence needs well under 20000 cycles
    initial begin
        #(1_000_000);
        bad_count++;
        conclude();
    end
endmodule
